/* File: hw/hmwdt_top.sv */
// hang monitor watchdog: timeout select, feed port and system reset request
`timescale 1ns/1ns
// What this block does
// RULE1 - timeout reached requests full system reset
// RULE2 - three-bit code selects 250 ms to 8 s
// RULE3 - code zero or the reserved code four disables; other codes start counting
// RULE4 - valid feed clears counter any time
// RULE5 - software writes 05 to feed periodically
// RULE6 - control write only within 30 us after feed
// RULE7 - other feed values do nothing
module hmwdt_top #(
    parameter longint BASE_CYC   = hmwdt_pkg::BASE_CYC,
    parameter int     WINDOW_CYC = hmwdt_pkg::WINDOW_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [31:0] addr,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    input  wire logic [7:0]  wr_data,
    output logic      [7:0]  rd_data,
    output logic             sys_reset_req
);

    // ======================================================================
    // parameter checks
    // the longest code runs 32 base periods; all of it must fit the counter
    localparam longint LONGEST_CYC = BASE_CYC * 32;

    if (BASE_CYC < 1) begin : g_base_low
        $error("base period must be at least one cycle");
    end

    if (LONGEST_CYC >= 64'h1_0000_0000) begin : g_base_high
        $error("base period does not fit the counter");
    end

    if (hmwdt_pkg::CNT_W != 32) begin : g_count_width
        $error("counter width must match the limit checked here");
    end

    if (WINDOW_CYC < 1) begin : g_window_low
        $error("feed window must last at least one cycle");
    end

    if (WINDOW_CYC > 65535) begin : g_window_high
        $error("feed window does not fit its timer");
    end

    if (hmwdt_pkg::CODE_LSB + hmwdt_pkg::CODE_W > 8) begin : g_code_field
        $error("code field lies outside the data byte");
    end

    if (hmwdt_pkg::TIMEOUT_SELECT_ADDR == hmwdt_pkg::FEED_PORT_ADDR) begin : g_addr_clash
        $error("control and feed ports share an address");
    end

    // ======================================================================
    // reset release
    logic [1:0] rst_pipe;
    logic       rst_sync_b;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    // reset asserts at once but leaves on a clock edge, two flops deep
    assign rst_sync_b = rst_pipe[1];

    // ======================================================================
    // helpers

    // timeout in cycles, zero for disabled or reserved
    function automatic logic [hmwdt_pkg::CNT_W-1:0] period_of(input logic [2:0] code);
        logic [hmwdt_pkg::CNT_W-1:0] base;
        base = hmwdt_pkg::CNT_W'(BASE_CYC);
        case (hmwdt_pkg::hmwdt_code_t'(code))                                      // RULE2
            hmwdt_pkg::HMWDT_250MS: period_of = base;
            hmwdt_pkg::HMWDT_500MS: period_of = base << 1;
            hmwdt_pkg::HMWDT_1S:    period_of = base << 2;
            hmwdt_pkg::HMWDT_2S:    period_of = base << 3;
            hmwdt_pkg::HMWDT_4S:    period_of = base << 4;
            hmwdt_pkg::HMWDT_8S:    period_of = base << 5;
            default:                period_of = '0;
        endcase
    endfunction

    function automatic logic hit(input logic [31:0] a, input logic [31:0] target);
        hit = (a == target);
    endfunction

    // control register decode; shared by the write and the read path
    function automatic logic is_ctl(input logic [31:0] a);
        is_ctl = hit(a, hmwdt_pkg::TIMEOUT_SELECT_ADDR);
    endfunction

    function automatic logic is_feed(input logic [31:0] a);
        is_feed = hit(a, hmwdt_pkg::FEED_PORT_ADDR);
    endfunction

    // only the code field is kept; the other data bits are dropped
    function automatic logic [2:0] code_field(input logic [7:0] d);
        code_field = d[hmwdt_pkg::CODE_LSB +: hmwdt_pkg::CODE_W];
    endfunction

    // true on the cycle whose increment would reach the period
    function automatic logic expires(input logic [hmwdt_pkg::CNT_W-1:0] count,
                                     input logic [hmwdt_pkg::CNT_W-1:0] limit);
        expires = (count + 1'b1 >= limit);
    endfunction

    // read word of the control register: code in its field, rest zero
    function automatic logic [7:0] ctl_word(input logic [2:0] code);
        logic [7:0] w;
        w = 8'h00;
        w[hmwdt_pkg::CODE_LSB +: hmwdt_pkg::CODE_W] = code;
        ctl_word = w;
    endfunction

    // ======================================================================
    // state
    typedef struct packed {
        logic [2:0]                  code;
        logic [hmwdt_pkg::CNT_W-1:0] count;
        logic                        fire;
        logic [7:0]                  rdata;
    } hmwdt_state_t;

    hmwdt_state_t r;
    hmwdt_state_t next_r;

    // value of the state while reset is held
    localparam hmwdt_state_t STATE_RST = '{
        code:  hmwdt_pkg::TIMEOUT_SELECT_RST,
        count: '0,
        fire:  1'b0,
        rdata: 8'h00
    };

    logic                        feed_ok;
    logic                        ctl_wr;
    logic                        ctl_rd;
    logic                        win_open;
    logic                        code_take;
    logic                        enabled;
    logic [hmwdt_pkg::CNT_W-1:0] period;

    // ======================================================================
    // access decode
    assign feed_ok   = wr_en && is_feed(addr)
                       && (wr_data == hmwdt_pkg::FEED_VALUE);                       // RULE7
    assign ctl_wr    = wr_en && is_ctl(addr);
    assign ctl_rd    = rd_en && is_ctl(addr);
    // control writes outside the feed window are dropped
    assign code_take = ctl_wr && win_open;                                          // RULE6

    // ======================================================================
    // period select
    assign period    = period_of(r.code);                                           // RULE2
    // disabled and reserved codes both give a zero period
    assign enabled   = (period != '0);                                              // RULE3

    // ======================================================================
    // feed window

    hmwdt_window #(
        .WINDOW_CYC (WINDOW_CYC)
    ) u_window (
        .clk         (clk),
        .rst_sync_b  (rst_sync_b),
        .open_pulse  (feed_ok),
        .close_pulse (ctl_wr),
        .is_open     (win_open)
    );

    // ======================================================================
    // next state
    always_comb begin
        next_r = r;

        // code register
        if (code_take) begin                                                        // RULE6
            next_r.code = code_field(wr_data);
        end

        // counter and reset request
        if (!enabled) begin                                                         // RULE3
            // held at zero so that a later enable starts a whole period
            next_r.count = '0;
        end else if (feed_ok) begin                                                 // RULE4
            // a feed on the final cycle still beats the request
            next_r.count = '0;
        end else if (expires(r.count, period)) begin
            // sticky until reset: the request itself resets the system
            next_r.fire  = 1'b1;                                                    // RULE1
        end else begin
            next_r.count = r.count + 1'b1;                                          // RULE3
        end

        // read data stands one cycle; the feed port reads as zero
        if (ctl_rd) begin
            next_r.rdata = ctl_word(r.code);
        end else begin
            next_r.rdata = 8'h00;
        end
    end

    // ======================================================================
    // state register

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            r <= STATE_RST;
        end else begin
            r <= next_r;
        end
    end

    // ======================================================================
    // outputs, straight from the state register
    assign rd_data       = r.rdata;
    assign sys_reset_req = r.fire;

endmodule

/* File: hw/hmwdt_pkg.sv */
// package: register map, codes and timing constants of the hang monitor
package hmwdt_pkg;

    // ======================================================================
    // register map
    localparam logic [31:0] TIMEOUT_SELECT_ADDR = 32'h2380_0000;
    localparam logic [31:0] FEED_PORT_ADDR      = 32'h23C0_0000;
    localparam logic [7:0]  FEED_VALUE          = 8'h05;
    localparam int          CODE_LSB            = 0;
    localparam int          CODE_W              = 3;
    localparam logic [2:0]  TIMEOUT_SELECT_RST  = 3'h0;

    // ======================================================================
    // timing
    localparam int          CLK_HZ              = 125_000_000;
    localparam int          CLK_NS              = 8;
    localparam int          WINDOW_US           = 30;
    // longest time: round down
    localparam int          WINDOW_CYC          = (WINDOW_US * 1000) / CLK_NS;
    localparam int          BASE_MS             = 250;
    localparam longint      BASE_CYC            = (longint'(BASE_MS) * CLK_HZ) / 1000;
    localparam int          CNT_W               = 32;

    // ======================================================================
    // timeout codes
    typedef enum logic [2:0] {
        HMWDT_OFF   = 3'h0,
        HMWDT_250MS = 3'h1,
        HMWDT_500MS = 3'h2,
        HMWDT_1S    = 3'h3,
        HMWDT_RSVD  = 3'h4,
        HMWDT_2S    = 3'h5,
        HMWDT_4S    = 3'h6,
        HMWDT_8S    = 3'h7
    } hmwdt_code_t;

endpackage

/* File: hw/hmwdt_window.sv */
// feed-to-control write window timer
`timescale 1ns/1ns
module hmwdt_window #(
    parameter int WINDOW_CYC = hmwdt_pkg::WINDOW_CYC
) (
    input  wire logic clk,
    input  wire logic rst_sync_b,
    input  wire logic open_pulse,
    input  wire logic close_pulse,
    output logic      is_open
);

    if (WINDOW_CYC < 1 || WINDOW_CYC > 65535) begin : g_window_range
        $error("window length out of range");
    end

    typedef struct packed {
        logic [15:0] left;
    } hmwdt_win_t;

    hmwdt_win_t r;
    hmwdt_win_t next_r;

    always_comb begin
        next_r = r;
        if (r.left != 16'h0000) begin
            next_r.left = r.left - 16'h0001;
        end
        // one control write per feed
        if (close_pulse) begin
            next_r.left = 16'h0000;
        end
        // a feed restarts the window even if a write closes it this cycle
        if (open_pulse) begin
            next_r.left = 16'(WINDOW_CYC);
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign is_open = (r.left != 16'h0000);

endmodule

/* File: verif/hmwdt_checker.sv */
// port-level assertions for the hang monitor, with bind
`timescale 1ns/1ns
module hmwdt_checker #(
    parameter longint BASE_CYC   = 20,
    parameter int     WINDOW_CYC = 10
) (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [31:0] addr,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [7:0]  wr_data,
    input wire logic [7:0]  rd_data,
    input wire logic        sys_reset_req
);
    // ====================
    // properties
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire rc = rd_en && addr == hmwdt_pkg::TIMEOUT_SELECT_ADDR;
    wire fd = wr_en && addr == hmwdt_pkg::FEED_PORT_ADDR && wr_data == 8'h05;
    property p_stick; sys_reset_req |=> sys_reset_req; endproperty
    a_stick: assert property (p_stick) else $error("request dropped");
    // a feed must win even against the final count
    property p_feed; fd && !sys_reset_req |=> !sys_reset_req; endproperty
    a_feed: assert property (p_feed) else $error("fired after feed");
    property p_hi; rc |=> rd_data[7:3] == 5'h00; endproperty
    a_hi: assert property (p_hi) else $error("upper bits set");
    property p_off; rc ##1 (rd_data[1:0] == 2'h0 && !sys_reset_req)
        |=> !sys_reset_req; endproperty
    a_off: assert property (p_off) else $error("fired while off");
    property p_fr; rd_en && !rc |=> rd_data == 8'h00; endproperty
    a_fr: assert property (p_fr) else $error("feed read not zero");
    property p_idle; !rd_en |=> rd_data == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("stale read data");
endmodule
bind hmwdt_top hmwdt_checker #(.BASE_CYC(BASE_CYC), .WINDOW_CYC(WINDOW_CYC)) u_chk (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .wr_data(wr_data), .rd_data(rd_data), .sys_reset_req(sys_reset_req));

/* File: verif/tb.sv */
// directed testbench for the hang monitor
`timescale 1ns/1ns
module tb;
    // ====================
    // harness
    localparam int          B = 20;
    localparam int          W = 10;
    localparam logic [31:0] C = hmwdt_pkg::TIMEOUT_SELECT_ADDR;
    localparam logic [31:0] F = hmwdt_pkg::FEED_PORT_ADDR;
    logic        clk = 0, rst_b = 0, wr_en = 0, rd_en = 0, sys_reset_req;
    logic [31:0] addr = 0;
    logic [7:0]  wr_data = 0, rd_data, q;
    int          errors = 0, tests_run = 0, cyc = 0;
    int          m[8] = '{0, 1, 2, 4, 0, 8, 16, 32};
    always #4 clk = ~clk;
    hmwdt_top #(.BASE_CYC(B), .WINDOW_CYC(W)) uut (.clk(clk), .rst_b(rst_b), .addr(addr),
        .wr_en(wr_en), .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data),
        .sys_reset_req(sys_reset_req));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // hang guard: far above the longest period sum
    always @(posedge clk) if (++cyc == 20000) begin
        errors++;
        end_sim;
    end
    // two cycles per access so strobes never toggle twice in one step
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        addr = a;
        wr_data = d;
        wr_en = 1;
        @(negedge clk) wr_en = 0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [31:0] a);
        addr = a;
        rd_en = 1;
        @(negedge clk) rd_en = 0;
        q = rd_data;
        @(negedge clk);
    endtask
    task automatic rst;
        rst_b = 0;
        repeat (2) @(negedge clk);
        rst_b = 1;
        repeat (3) @(negedge clk);
    endtask
    // p: cycles from the last valid feed to the request; entered on the
    // fourth falling edge after that feed, so k lags p by two
    task automatic fire(input int p);
        int k;
        k = 1;
        while (sys_reset_req !== 1'b1 && k < 2000) begin
            @(negedge clk);
            k++;
        end
        chk(16'(k), 16'(p - 2));
    endtask
    // ====================
    // scenarios
    task automatic t_refuse;
        rst;
        rd(32'h2380_0004);
        chk(q, 0);
        wr(C, 1);
        rd(C);
        chk(q, 0);
        wr(F, 6);
        wr(C, 1);
        rd(C);
        chk(q, 0);
        wr(F, 5);
        // first cycle past the window
        repeat (W - 1) @(negedge clk);
        wr(C, 1);
        rd(C);
        chk(q, 0);
        wr(F, 5);
        repeat (W - 2) @(negedge clk);
        wr(C, 8'hFA);
        wr(C, 3);
        rd(C);
        chk(q, 2);
    endtask
    task automatic t_codes;
        for (int i = 0; i < 8; i++) begin
            rst;
            wr(F, 5);
            wr(C, 1);
            wr(F, 5);
            wr(C, 8'(i));
            if (m[i] == 0) begin
                repeat (33 * B) @(negedge clk);
                chk(sys_reset_req, 0);
            end else fire(m[i] * B);
            rd(C);
            chk(q, 16'(i));
        end
    endtask
    task automatic t_feed;
        rst;
        wr(F, 5);
        wr(C, 1);
        repeat (3) begin
            repeat (B - 6) @(negedge clk);
            wr(F, 5);
        end
        wr(F, 8'h50);
        fire(B);
    endtask
    initial begin
        t_refuse;
        t_codes;
        t_feed;
        end_sim;
    end
endmodule
